// ==== rtl/gpcd_gpio.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module gpcd_gpio import gpcd_pkg::*; (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Port C pads
    input  wire logic [15:0] c_pin_in,
    output logic [15:0]      c_pin_out,
    output logic [15:0]      c_pin_oe,
    output logic [15:0]      c_pulldown_en,
    // Port D pads
    input  wire logic [15:0] d_pin_in,
    output logic [15:0]      d_pin_out,
    output logic [15:0]      d_pin_oe,
    output logic [15:0]      d_pulldown_en,
    // Port E pads
    input  wire logic [15:0] e_pin_in,
    output logic [15:0]      e_pin_out,
    output logic [15:0]      e_pin_oe,
    output logic [15:0]      e_pulldown_en,
    // Display controller signals
    input  wire logic [23:0] lcd_pixel_bus,
    input  wire logic        line_end_pulse,
    input  wire logic        lcd_pixel_clock,
    input  wire logic        lcd_line_sync,
    input  wire logic        lcd_frame_sync,
    input  wire logic        lcd_alt_polarity,
    input  wire logic        panel_output_enable,
    input  wire logic        panel_reverse,
    input  wire logic        panel_reverse_inverted,
    // Audio serial and SPI signals
    output logic             audio_serial_data_in,
    output logic             spi0_slave_select_n,
    output logic             spi1_slave_select_n,
    input  wire logic        spi1_serial_clock_out,
    input  wire logic        spi1_serial_clock_oe,
    output logic             spi1_serial_clock_in,
    input  wire logic        spi1_master_out,
    input  wire logic        spi1_master_out_oe,
    output logic             spi1_master_out_in,
    input  wire logic        spi1_master_in_out,
    input  wire logic        spi1_master_in_oe,
    output logic             spi1_master_in,
    input  wire logic        spi1_chip_select_n
);

    // ==========================================================================
    // Address decode
    // Word address only; byte offset bits are ignored as the bus permits.
    function automatic gpcd_reg_t reg_kind(input logic [31:0] a);
        logic [31:0] w;
        w = {a[31:2], 2'b00};
        if (w == ADDR_C_SEL || w == ADDR_D_SEL || w == ADDR_E_SEL) begin
            return REG_SEL;
        end else if (w == ADDR_C_LVL || w == ADDR_D_LVL || w == ADDR_E_LVL) begin
            return REG_LVL;
        end else if (w == ADDR_C_DN || w == ADDR_D_DN || w == ADDR_E_DN) begin
            return REG_DN;
        end else if (w == ADDR_C_RSV || w == ADDR_D_RSV || w == ADDR_E_RSV) begin
            return REG_RSV;
        end else begin
            return REG_NONE;
        end
    endfunction : reg_kind

    // Port index from the 16-byte block number; valid only when the kind hits.
    function automatic logic [1:0] port_of(input logic [31:0] a);
        logic [2:0] t;
        t = a[6:4] - 3'h2;
        return t[1:0];
    endfunction : port_of

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // ==========================================================================
    // Storage
    logic [2:0][31:0] sel_r;
    logic [2:0][15:0] lvl_r, dn_r, pin_out_r, pin_oe_r, pin_in_a;
    logic [2:0][15:0] out_nxt, oe_nxt, lvl_rd, func_o, func_e, alt_o, alt_e;
    // Bus channel state.
    logic             aw_full_r, w_full_r, bvalid_r, rvalid_r, do_write;
    logic [31:0]      aw_addr_r, w_data_r, rdata_r;
    logic [3:0]       w_strb_r;
    logic [1:0]       bresp_r, rresp_r, wr_port, rd_port;
    gpcd_reg_t        wr_kind, rd_kind;

    // ==========================================================================
    // AXI4-Lite write path
    // Address and data are parked separately so either may arrive first.
    assign awready  = !aw_full_r && !bvalid_r;
    assign wready   = !w_full_r && !bvalid_r;
    assign do_write = aw_full_r && w_full_r && !bvalid_r;
    assign wr_kind  = reg_kind(aw_addr_r);
    assign wr_port  = port_of(aw_addr_r);
    assign bvalid   = bvalid_r;
    assign bresp    = bresp_r;

    // Write address holding register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
        end else if (awvalid && awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= awaddr;
        end else if (do_write) begin
            aw_full_r <= 1'b0;
        end
    end

    // Write data holding register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end else if (do_write) begin
            w_full_r <= 1'b0;
        end
    end

    // Write response; an address outside the map answers with an error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Register update; data bits are kept in every mode so a later switch
    // to output drives what software wrote earlier.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NPORT; p++) begin
                sel_r[p] <= SEL_RST;
                lvl_r[p] <= LVL_RST;
                dn_r[p]  <= DN_RST[p];
            end
        end else if (do_write) begin
            for (int p = 0; p < NPORT; p++) begin
                if (wr_port == 2'(p)) begin
                    if (wr_kind == REG_SEL) begin
                        sel_r[p] <= merge(sel_r[p], w_data_r, w_strb_r);
                    end else if (wr_kind == REG_LVL) begin
                        lvl_r[p] <= 16'(merge({16'h0, lvl_r[p]}, w_data_r, w_strb_r));
                    end else if (wr_kind == REG_DN) begin
                        dn_r[p] <= 16'(merge({16'h0, dn_r[p]}, w_data_r, w_strb_r));
                    end
                end
            end
        end
    end

    // ==========================================================================
    // AXI4-Lite read path
    // One read in flight; the answer comes one edge after the address.
    assign arready = !rvalid_r;
    assign rd_kind = reg_kind(araddr);
    assign rd_port = port_of(araddr);
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= (rd_kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (rd_kind == REG_SEL) begin
                rdata_r <= sel_r[rd_port];
            end else if (rd_kind == REG_LVL) begin
                rdata_r <= {16'h0000, lvl_rd[rd_port]};
            end else if (rd_kind == REG_DN) begin
                rdata_r <= {16'h0000, dn_r[rd_port]};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================================
    // Peripheral routing tables
    // Code 10 sources: display signals on C and D; port E functions live elsewhere.
    assign func_o[PORT_C] = {lcd_pixel_bus[7:0], panel_reverse_inverted, panel_reverse,
                             panel_output_enable, lcd_alt_polarity, lcd_frame_sync,
                             lcd_line_sync, lcd_pixel_clock, line_end_pulse};
    assign func_e[PORT_C] = 16'hffff;
    assign func_o[PORT_D] = lcd_pixel_bus[23:8];
    assign func_e[PORT_D] = 16'hffff;
    assign func_o[PORT_E] = 16'h0000;
    assign func_e[PORT_E] = 16'h0000;

    // Code 11 drivers; reserved codes and input-only alternates never drive.
    assign alt_o[PORT_C] = 16'h0000;
    assign alt_e[PORT_C] = 16'h0000;
    assign alt_o[PORT_D] = {5'h00, spi1_serial_clock_out, spi1_master_out, spi1_master_in_out,
                            6'h00, spi1_serial_clock_out, spi1_chip_select_n};
    assign alt_e[PORT_D] = {5'h00, spi1_serial_clock_oe, spi1_master_out_oe, spi1_master_in_oe,
                            6'h00, spi1_serial_clock_oe, 1'b1};
    assign alt_o[PORT_E] = 16'h0000;
    assign alt_e[PORT_E] = 16'h0000;

    assign pin_in_a = {e_pin_in, d_pin_in, c_pin_in};

    // ==========================================================================
    // Per-pin mode multiplexer
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        for (genvar n = 0; n < NPIN; n++) begin : g_pin
            logic [1:0] mode;
            assign mode = sel_r[p][2*n +: 2];
            // Output value and enable for the selected function.
            assign out_nxt[p][n] = (mode == MODE_OUT)  ? lvl_r[p][n] :
                                   (mode == MODE_FUNC) ? func_o[p][n] :
                                   (mode == MODE_ALT)  ? alt_o[p][n] : 1'b0;
            assign oe_nxt[p][n]  = (mode == MODE_OUT)  ? 1'b1 :
                                   (mode == MODE_FUNC) ? func_e[p][n] :
                                   (mode == MODE_ALT)  ? alt_e[p][n] : 1'b0;
            // Read-back: pin level for inputs, stored bit for outputs, zero otherwise.
            assign lvl_rd[p][n]  = (mode == MODE_IN)  ? pin_in_a[p][n] :
                                   (mode == MODE_OUT) ? lvl_r[p][n] : 1'b0;
        end
    end

    // Pads are registered so every pin output comes from a flip-flop; this
    // costs one cycle of latency on routed display and SPI signals.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0;
        end else begin
            pin_out_r <= out_nxt;
            pin_oe_r  <= oe_nxt;
        end
    end

    assign c_pin_out = pin_out_r[PORT_C];
    assign c_pin_oe  = pin_oe_r[PORT_C];
    assign d_pin_out = pin_out_r[PORT_D];
    assign d_pin_oe  = pin_oe_r[PORT_D];
    assign e_pin_out = pin_out_r[PORT_E];
    assign e_pin_oe  = pin_oe_r[PORT_E];

    // Pull-downs follow only their own register, whatever the pin mode.
    assign c_pulldown_en = ~dn_r[PORT_C];
    assign d_pulldown_en = ~dn_r[PORT_D];
    assign e_pulldown_en = ~dn_r[PORT_E];

    // ==========================================================================
    // Pin levels fed to peripherals
    // Unselected inputs sit at their idle level so a peripheral sees no edges.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            audio_serial_data_in <= 1'b0;
            spi0_slave_select_n  <= 1'b1;
            spi1_slave_select_n  <= 1'b1;
            spi1_serial_clock_in <= 1'b0;
            spi1_master_out_in   <= 1'b0;
            spi1_master_in       <= 1'b0;
        end else begin
            audio_serial_data_in <= (sel_r[PORT_C][2*C_PIN_AUDIO +: 2] == MODE_ALT)
                                    && c_pin_in[C_PIN_AUDIO];
            spi0_slave_select_n  <= (sel_r[PORT_D][2*D_PIN_SS0 +: 2] == MODE_ALT)
                                    ? d_pin_in[D_PIN_SS0] : 1'b1;
            spi1_slave_select_n  <= (sel_r[PORT_D][2*D_PIN_SS1 +: 2] == MODE_ALT)
                                    ? d_pin_in[D_PIN_SS1] : 1'b1;
            if (sel_r[PORT_D][2*D_PIN_CLK +: 2] == MODE_ALT) begin
                spi1_serial_clock_in <= d_pin_in[D_PIN_CLK];
            end else if (sel_r[PORT_D][2*D_PIN_CLK2 +: 2] == MODE_ALT) begin
                spi1_serial_clock_in <= d_pin_in[D_PIN_CLK2];
            end else begin
                spi1_serial_clock_in <= 1'b0;
            end
            spi1_master_out_in   <= (sel_r[PORT_D][2*D_PIN_MOSI +: 2] == MODE_ALT)
                                    && d_pin_in[D_PIN_MOSI];
            spi1_master_in       <= (sel_r[PORT_D][2*D_PIN_MISO +: 2] == MODE_ALT)
                                    && d_pin_in[D_PIN_MISO];
        end
    end

    // ==========================================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_input_float: assert property ((sel_r[PORT_D][1:0] == MODE_IN) |=> !d_pin_oe[0])
        else $error("input pin is driven");
    chk_output_drive: assert property ((sel_r[PORT_C][3:2] == MODE_OUT) |=>
        (c_pin_oe[1] && c_pin_out[1] == $past(lvl_r[PORT_C][1])))
        else $error("output pin does not follow its data bit");
    chk_line_end_route: assert property ((sel_r[PORT_C][1:0] == MODE_FUNC) |=>
        (c_pin_oe[0] && c_pin_out[0] == $past(line_end_pulse)))
        else $error("line end not routed to port C pin 0");
    chk_pixel_c8: assert property ((sel_r[PORT_C][17:16] == MODE_FUNC) |=>
        (c_pin_out[8] == $past(lcd_pixel_bus[0])))
        else $error("pixel bit 0 not on port C pin 8");
    chk_pixel_d15: assert property ((sel_r[PORT_D][31:30] == MODE_FUNC) |=>
        (d_pin_out[15] == $past(lcd_pixel_bus[23])))
        else $error("pixel bit 23 not on port D pin 15");
    chk_spi0_select: assert property ((sel_r[PORT_D][31:30] == MODE_ALT) |=>
        (spi0_slave_select_n == $past(d_pin_in[15]) && !d_pin_oe[15]))
        else $error("SPI0 slave select not taken from port D pin 15");
    chk_spi1_clock: assert property ((sel_r[PORT_D][21:20] == MODE_ALT) |=>
        (d_pin_oe[10] == $past(spi1_serial_clock_oe)))
        else $error("SPI1 clock enable not on port D pin 10");
    chk_reserved_float: assert property ((sel_r[PORT_D][5:4] == MODE_ALT) |=> !d_pin_oe[2])
        else $error("reserved code drives a pin");
    chk_audio_route: assert property ((sel_r[PORT_C][9:8] == MODE_ALT) |=>
        (audio_serial_data_in == $past(c_pin_in[4])))
        else $error("audio input not taken from port C pin 4");
    chk_reset_state: assert property ($rose(aresetn) |->
        (d_pulldown_en == 16'h0fff && d_pin_oe == 16'h0000))
        else $error("port D reset state wrong");
    chk_read_answer: assert property ((arvalid && arready) |=> rvalid) else $error("read not answered in one cycle");
    chk_write_answer: assert property (do_write |=> (bvalid && !aw_full_r && !w_full_r))
        else $error("write not answered in one cycle");

    cov_write_done: cover property (bvalid && bready);
    cov_read_done: cover property (rvalid && rready);
    cov_audio_alt: cover property (sel_r[PORT_C][9:8] == MODE_ALT);
    cov_d_output: cover property (d_pin_oe[0] && sel_r[PORT_D][1:0] == MODE_OUT);

endmodule : gpcd_gpio

// ==== rtl/gpcd_pkg.sv ====
// How it works
// - Each pin has a 2-bit field: 00 input, 01 output, 10 display on ports C and D, 11 alternate function or reserved.
// - Port C pin 4: code 10 alternate-line polarity, code 11 audio serial data in.
// - Port C code 10: pins 0-3 line end, pixel clock, line sync, frame sync; 5-7 panel.
// - Port C code 10: pins 8-15 carry pixel bits 0-7, ascending.
// - Port D code 10: pins 0-15 carry pixel bits 8-23, ascending.
// - Port D code 11: pin 15 SPI0 slave select, pin 14 SPI1 slave select.
// - Port D code 11: pins 10, 9, 8 carry SPI1 clock, master out, master in.
// - Port D code 11: pin 1 SPI1 clock, pin 0 SPI1 chip select; others reserved.
// - An input pin reads back its current level.
// - An output pin is driven with its data register bit.
// - A peripheral pin reads back an undefined value; here zero.
// - Pull-down bit 0 enables the pull-down, 1 disables it, on all 16 pins.
// - Port D registers sit at 0x56000030, 0x34, 0x38; 0x3c is reserved.
// - Port D resets to all inputs, pull-down register 0xf000.
// - Port E registers sit at 0x56000040, 0x44, 0x48; selection and pull-down reset zero.
// - All selection, data and pull-down registers are readable and writable.
// - Every port C and D pin supports both input and output mode.
// - An enabled pull-down acts whatever function the pin has.
// - Port C registers sit at 0x56000020, 0x24, 0x28; reset to zero.
package gpcd_pkg;

    // ==========================================================================
    // Register map
    localparam logic [31:0] ADDR_C_SEL = 32'h5600_0020;
    localparam logic [31:0] ADDR_C_LVL = 32'h5600_0024;
    localparam logic [31:0] ADDR_C_DN  = 32'h5600_0028;
    localparam logic [31:0] ADDR_C_RSV = 32'h5600_002c;
    localparam logic [31:0] ADDR_D_SEL = 32'h5600_0030;
    localparam logic [31:0] ADDR_D_LVL = 32'h5600_0034;
    localparam logic [31:0] ADDR_D_DN  = 32'h5600_0038;
    localparam logic [31:0] ADDR_D_RSV = 32'h5600_003c;
    localparam logic [31:0] ADDR_E_SEL = 32'h5600_0040;
    localparam logic [31:0] ADDR_E_LVL = 32'h5600_0044;
    localparam logic [31:0] ADDR_E_DN  = 32'h5600_0048;
    localparam logic [31:0] ADDR_E_RSV = 32'h5600_004c;

    // ==========================================================================
    // Ports, pins and field codes
    localparam int          NPORT       = 3;
    localparam int          NPIN        = 16;
    localparam int          PORT_C      = 0;
    localparam int          PORT_D      = 1;
    localparam int          PORT_E      = 2;
    localparam logic [1:0]  MODE_IN     = 2'h0;
    localparam logic [1:0]  MODE_OUT    = 2'h1;
    localparam logic [1:0]  MODE_FUNC   = 2'h2;
    localparam logic [1:0]  MODE_ALT    = 2'h3;
    localparam int          C_PIN_AUDIO = 4;
    localparam int          D_PIN_SS0   = 15;
    localparam int          D_PIN_SS1   = 14;
    localparam int          D_PIN_CLK   = 10;
    localparam int          D_PIN_MOSI  = 9;
    localparam int          D_PIN_MISO  = 8;
    localparam int          D_PIN_CLK2  = 1;

    // ==========================================================================
    // Reset values, indexed by port (C lowest)
    localparam logic [31:0]             SEL_RST = 32'h0000_0000;
    localparam logic [15:0]             LVL_RST = 16'h0000;
    localparam logic [2:0][15:0]        DN_RST  = {16'h0000, 16'hf000, 16'h0000};

    // ==========================================================================
    // Bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum {REG_SEL, REG_LVL, REG_DN, REG_RSV, REG_NONE} gpcd_reg_t;

endpackage : gpcd_pkg

// ==== test/gpcd_pads.sv ====
`timescale 1ns/10ps
module gpcd_pads (
    // Pad side
    input  wire logic        aclk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] pulldown_en,
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_en,
    output logic      [15:0] pin_in
);
    logic [15:0] last_r = 16'h0000;
    // A floating pin toggles, so a stale level never passes for a driven one.
    always_ff @(posedge aclk) last_r <= pin_in;
    // A pull-down acts whatever the pin's function.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & ~pulldown_en & ~last_r);
endmodule : gpcd_pads

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench import gpcd_pkg::*;;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic [2:0]  awprot, arprot;
    logic [1:0]  bresp, rresp;
    logic [15:0] c_pin_in, c_pin_out, c_pin_oe, c_pulldown_en, d_pin_in, d_pin_out, d_pin_oe, d_pulldown_en;
    logic [15:0] e_pin_in, e_pin_out, e_pin_oe, e_pulldown_en, c_ext, c_ext_en, d_ext, d_ext_en;
    logic [23:0] lcd_pixel_bus;
    logic        line_end_pulse, lcd_pixel_clock, lcd_line_sync, lcd_frame_sync, lcd_alt_polarity;
    logic        panel_output_enable, panel_reverse, panel_reverse_inverted, audio_serial_data_in;
    logic        spi0_slave_select_n, spi1_slave_select_n, spi1_serial_clock_out, spi1_serial_clock_oe;
    logic        spi1_serial_clock_in, spi1_master_out, spi1_master_out_oe, spi1_master_out_in;
    logic        spi1_master_in_out, spi1_master_in_oe, spi1_master_in, spi1_chip_select_n;
    int          mismatches, checks_done;
    gpcd_gpio dut (.*);
    gpcd_pads pc (.aclk, .pin_out(c_pin_out), .pin_oe(c_pin_oe), .pulldown_en(c_pulldown_en),
                  .ext_val(c_ext), .ext_en(c_ext_en), .pin_in(c_pin_in));
    gpcd_pads pd (.aclk, .pin_out(d_pin_out), .pin_oe(d_pin_oe), .pulldown_en(d_pulldown_en),
                  .ext_val(d_ext), .ext_en(d_ext_en), .pin_in(d_pin_in));
    // ==========================================================================
    // Checking and bus tasks
    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Each channel is released at the edge that takes it; a lost answer ends the run.
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        repeat (50) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                bready <= 1'h0;
                chk({30'h0, bresp}, 32'h0);
                return;
            end
        end
        chk({31'h0, bvalid}, 32'h1);
        wrap_up();
    endtask : axw
    task automatic axr(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        repeat (50) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                rready <= 1'h0;
                chk(rdata, e);
                chk({30'h0, rresp}, {30'h0, r});
                return;
            end
        end
        chk({31'h0, rvalid}, 32'h1);
        wrap_up();
    endtask : axr
    // Pads follow a register write one edge after it lands.
    task automatic pause;
        repeat (3) @(posedge aclk);
        #1;
    endtask : pause
    // ==========================================================================
    // Scenarios
    task automatic t_reset;
        chk({16'h0, d_pulldown_en}, 32'h0fff);
        chk({c_pulldown_en, e_pulldown_en}, 32'hffff_ffff);
        chk({e_pin_out, e_pin_oe}, 32'h0);
        axr(ADDR_D_DN, 32'hf000, RESP_OKAY);
        axr(ADDR_D_SEL, 32'h0, RESP_OKAY);
        axr(ADDR_C_DN, 32'h0, RESP_OKAY);
        axr(ADDR_E_DN, 32'h0, RESP_OKAY);
        axr(ADDR_D_RSV, 32'h0, RESP_OKAY);
        axr(32'h5600_0080, 32'h0, RESP_SLVERR);
    endtask : t_reset
    task automatic t_out;
        axw(ADDR_D_LVL, 32'ha55a);
        pause();
        chk({16'h0, d_pin_oe}, 32'h0);
        axw(ADDR_D_SEL, 32'h5555_5555);
        axw(ADDR_C_SEL, 32'h5555_5555);
        axw(ADDR_C_LVL, 32'h3c3c);
        pause();
        chk({d_pin_out, d_pin_oe}, 32'ha55a_ffff);
        chk({c_pin_out, c_pin_oe}, 32'h3c3c_ffff);
        axr(ADDR_D_LVL, 32'ha55a, RESP_OKAY);
    endtask : t_out
    task automatic t_in;
        {d_ext, d_ext_en} <= 32'h1234_ffff;
        axw(ADDR_D_SEL, 32'h0);
        pause();
        axr(ADDR_D_LVL, 32'h1234, RESP_OKAY);
        d_ext_en <= 16'h0;
        axw(ADDR_D_DN, 32'h0);
        pause();
        axr(ADDR_D_LVL, 32'h0, RESP_OKAY);
    endtask : t_in
    task automatic t_disp;
        lcd_pixel_bus <= 24'h5a3c96;
        {panel_reverse_inverted, panel_reverse, panel_output_enable, lcd_alt_polarity, lcd_frame_sync,
         lcd_line_sync, lcd_pixel_clock, line_end_pulse} <= 8'ha6;
        axw(ADDR_D_SEL, 32'haaaa_aaaa);
        axw(ADDR_C_SEL, 32'haaaa_aaaa);
        pause();
        chk({c_pin_out, d_pin_out}, 32'h96a6_5a3c);
        axr(ADDR_D_LVL, 32'h0, RESP_OKAY);
    endtask : t_disp
    task automatic t_spi;
        {d_ext, d_ext_en, c_ext, c_ext_en} <= 64'h4100_c100_0010_ffff;
        {spi1_serial_clock_out, spi1_serial_clock_oe, spi1_master_out, spi1_master_out_oe} <= 4'hf;
        spi1_chip_select_n <= 1'h0;
        axw(ADDR_D_SEL, 32'hf03f_0033);
        axw(ADDR_C_SEL, 32'h0000_0303);
        pause();
        chk({30'h0, spi0_slave_select_n, spi1_slave_select_n}, 32'h1);
        chk({28'h0, spi1_master_in, audio_serial_data_in, spi1_serial_clock_in, spi1_master_out_in}, 32'hf);
        chk({26'h0, d_pin_oe[10:9], d_pin_out[10:9], d_pin_oe[0], d_pin_out[0]}, 32'h3e);
        chk({30'h0, d_pin_oe[2], c_pin_oe[0]}, 32'h0);
        axw(ADDR_D_SEL, 32'h0000_000c);
        pause();
        chk({29'h0, d_pin_oe[1], d_pin_out[1], spi1_serial_clock_in}, 32'h7);
    endtask : t_spi
    // ==========================================================================
    // Clock, reset and main sequence
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr} = '0;
        {awprot, arprot, e_pin_in, c_ext, c_ext_en, d_ext, d_ext_en, lcd_pixel_bus} = '0;
        {line_end_pulse, lcd_pixel_clock, lcd_line_sync, lcd_frame_sync, lcd_alt_polarity} = '0;
        {panel_output_enable, panel_reverse, panel_reverse_inverted, spi1_chip_select_n} = '0;
        {spi1_serial_clock_out, spi1_serial_clock_oe, spi1_master_out, spi1_master_out_oe} = '0;
        {spi1_master_in_out, spi1_master_in_oe, mismatches, checks_done} = '0;
        wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_out();
        t_in();
        t_disp();
        t_spi();
        // A second reset in mid-run must restore the reset values that t_reset checks.
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        wrap_up();
    end
endmodule : testbench
